// [inc/audio_ctl_pkg.sv]
// Constants shared by the audio control register bank and its volume ramps.
// Assumes a 125 MHz core clock; register offsets are page-local byte addresses.
package audio_ctl_pkg;

	// Widths of the control port
	localparam int ADDR_W = 7;
	localparam int PAGE_W = 8;
	localparam int BOOK_W = 8;
	localparam int DATA_W = 8;

	// Register offsets within page 0 of book 0
	localparam logic [ADDR_W-1:0] OFS_MUTE = 7'h03;
	localparam logic [ADDR_W-1:0] OFS_PLL  = 7'h04;
	localparam logic [ADDR_W-1:0] OFS_WRAP = 7'h06;
	localparam logic [ADDR_W-1:0] OFS_FILT = 7'h07;
	localparam logic [ADDR_W-1:0] OFS_PIN  = 7'h08;

	// Field positions
	localparam int BIT_LMUTE  = 4;
	localparam int BIT_RMUTE  = 0;
	localparam int BIT_LOCK   = 4;
	localparam int BIT_PLLEN  = 0;
	localparam int BIT_WRAP   = 3;
	localparam int BIT_EMPH   = 4;
	localparam int BIT_SDSEL  = 0;
	localparam int BIT_GPIO2_DRIVE_ENABLE   = 5;
	localparam int BIT_MUTE_LINE_ENABLE = 4;
	localparam int BIT_GPIO0_DRIVE_ENABLE   = 3;

	// Values after reset
	localparam logic RST_LMUTE  = 1'b0;
	localparam logic RST_RMUTE  = 1'b0;
	localparam logic RST_PLLEN  = 1'b1;
	localparam logic RST_WRAP   = 1'b0;
	localparam logic RST_EMPH   = 1'b0;
	localparam logic RST_SDSEL  = 1'b1;
	localparam logic RST_GPIO2_DRIVE_ENABLE   = 1'b0;
	localparam logic RST_MUTE_LINE_ENABLE = 1'b0;
	localparam logic RST_GPIO0_DRIVE_ENABLE   = 1'b0;

	// Auto-increment page boundaries
	localparam logic [ADDR_W-1:0] PAGE_END        = 7'h7F;
	localparam logic [ADDR_W-1:0] NEXT_PAGE_START = 7'h08;
	localparam logic [ADDR_W-1:0] SAME_PAGE_START = 7'h00;
	localparam logic [BOOK_W-1:0] BOOK_ZERO       = 8'h00;
	localparam logic [PAGE_W-1:0] PAGE_ZERO       = 8'h00;

	// Volume ramp timing: one gain step per interval, rounded up to cycles
	localparam int CLK_PERIOD_NS = 8;
	localparam int RAMP_STEP_NS  = 1000;
	localparam int RAMP_STEP_CYC = (RAMP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// [inc/ramp_if.sv]
// Carrier between the register bank and one channel's volume ramp.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface ramp_if #(parameter int GAIN_W = 8);
	logic              mute_req;
	logic [GAIN_W-1:0] gain;
	logic              muted;

	modport ctrl (output mute_req, input gain, input muted);
	modport ramp (input mute_req, output gain, output muted);
endinterface

// [rtl/volume_ramp.sv]
// Soft mute ramp for one audio channel: walks the gain one step at a time.
// Assumes a synchronised reset and a mute request from the same clock.
`timescale 1ns/1ps
module volume_ramp #(
	parameter int GAIN_W   = 8,
	parameter int STEP_CYC = audio_ctl_pkg::RAMP_STEP_CYC
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	ramp_if.ramp     bus
);
	import audio_ctl_pkg::*;

	localparam int CNT_W = $clog2(STEP_CYC + 1);
	localparam logic [CNT_W-1:0]  STEP_LAST = CNT_W'(STEP_CYC - 1);
	localparam logic [GAIN_W-1:0] GAIN_MAX  = '1;
	localparam logic [GAIN_W-1:0] GAIN_MIN  = '0;

	logic [CNT_W-1:0]  step_cnt_r, step_cnt_nxt;
	logic [GAIN_W-1:0] gain_r,     gain_nxt;
	logic              muted_r,    muted_nxt;

	// One gain step per interval, down while muting, up otherwise
	always_comb begin
		step_cnt_nxt = step_cnt_r + 1'b1;
		gain_nxt     = gain_r;
		if (step_cnt_r == STEP_LAST) begin
			step_cnt_nxt = '0;
			if (bus.mute_req && gain_r != GAIN_MIN) begin
				gain_nxt = gain_r - 1'b1;
			end else if (!bus.mute_req && gain_r != GAIN_MAX) begin
				gain_nxt = gain_r + 1'b1;
			end
		end
		muted_nxt = (gain_nxt == GAIN_MIN);
	end

	// Ramp state, full volume after reset
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			step_cnt_r <= '0;
			gain_r     <= '1;
			muted_r    <= 1'b0;
		end else begin
			step_cnt_r <= step_cnt_nxt;
			gain_r     <= gain_nxt;
			muted_r    <= muted_nxt;
		end
	end

	assign bus.gain  = gain_r;
	assign bus.muted = muted_r;

	sequence s_mute_held;
		bus.mute_req ##1 bus.mute_req;
	endsequence

	sequence s_unmute_held;
		!bus.mute_req ##1 !bus.mute_req;
	endsequence

	a_ramp_never_up: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		s_mute_held |-> gain_r <= $past(gain_r))
		else $error("gain rose while mute was held");

	a_ramp_never_down: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		s_unmute_held |-> gain_r >= $past(gain_r))
		else $error("gain fell while unmuted");

	a_ramp_single_step: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(bus.mute_req && gain_r != GAIN_MIN && step_cnt_r == STEP_LAST)
		|=> gain_r == $past(gain_r) - 1'b1)
		else $error("gain did not drop by exactly one step");

endmodule // volume_ramp

// [rtl/audio_dac_control_regs.sv]
// Control register bank of the amplifier's processing core: mute, PLL, page wrap,
// filter and output select, pin direction. Behind the control port's byte access.
// Assumes the control port logic and the PLL lock indicator; lock and audio pins async.
`timescale 1ns/1ps
module audio_dac_control_regs #(
	parameter int GAIN_W   = 8,
	parameter int STEP_CYC = audio_ctl_pkg::RAMP_STEP_CYC
) (
	input  wire logic                              sys_clk_i,
	input  wire logic                              rst_n_i,
	input  wire logic                              ctl_load_i,
	input  wire logic [audio_ctl_pkg::ADDR_W-1:0]  ctl_addr_i,
	input  wire logic [audio_ctl_pkg::PAGE_W-1:0]  ctl_page_i,
	input  wire logic [audio_ctl_pkg::BOOK_W-1:0]  ctl_book_i,
	input  wire logic                              ctl_wr_i,
	input  wire logic [audio_ctl_pkg::DATA_W-1:0]  ctl_wdata_i,
	input  wire logic                              ctl_rd_i,
	output logic      [audio_ctl_pkg::DATA_W-1:0]  ctl_rdata_o,
	output logic                                   ctl_rvalid_o,
	output logic      [audio_ctl_pkg::ADDR_W-1:0]  ctl_ptr_o,
	output logic      [audio_ctl_pkg::PAGE_W-1:0]  ctl_page_o,
	input  wire logic                              pll_raw_lock_i,
	input  wire logic                              pre_sdata_i,
	input  wire logic                              post_sdata_i,
	output logic                                   pll_enable_o,
	output logic                                   mclk_from_pin_o,
	output logic                                   pll_lock_flag_o,
	output logic      [GAIN_W-1:0]                 left_gain_o,
	output logic      [GAIN_W-1:0]                 right_gain_o,
	output logic                                   left_muted_o,
	output logic                                   right_muted_o,
	output logic                                   emphasis_undo_enable_o,
	output logic                                   serial_audio_output_o,
	output logic                                   gpio2_drive_enable_o,
	output logic                                   gpio0_drive_enable_o,
	output logic                                   mute_line_enable_o
);
	import audio_ctl_pkg::*;

	logic                rst_meta_r, rst_sync_r;
	logic [2:0]          in_meta_r,  in_sync_r;
	logic                lock_s, pre_s, post_s;
	logic                left_mute_r, left_mute_nxt, right_mute_r, right_mute_nxt;
	logic                pll_en_r,    pll_en_nxt,    unlock_r,     unlock_nxt;
	logic                clk_pin_r,   clk_pin_nxt,   wrap_sel_r,   wrap_sel_nxt;
	logic                emph_r,      emph_nxt,      sdsel_r,      sdsel_nxt;
	logic                gpio2_drive_enable_r,      gpio2_drive_enable_nxt,      mute_line_enable_r,     mute_line_enable_nxt;
	logic                gpio0_drive_enable_r,      gpio0_drive_enable_nxt,      serial_audio_output_r,      serial_audio_output_nxt;
	logic [ADDR_W-1:0]   ptr_r,       ptr_nxt;
	logic [PAGE_W-1:0]   page_r,      page_nxt;
	logic [DATA_W-1:0]   rdata_r,     rdata_nxt;
	logic                rvalid_r,    rvalid_nxt;
	logic                access, in_bank, wr_hit, rd_hit;

	// Byte image of one register; reserved bits stay zero
	function automatic logic [DATA_W-1:0] reg_image(input logic [ADDR_W-1:0] ofs);
		logic [DATA_W-1:0] v;
		v = '0;
		case (ofs)
			OFS_MUTE: begin
				v[BIT_LMUTE] = left_mute_r;
				v[BIT_RMUTE] = right_mute_r;
			end
			OFS_PLL: begin
				v[BIT_LOCK]  = unlock_r;
				v[BIT_PLLEN] = pll_en_r;
			end
			OFS_WRAP: v[BIT_WRAP] = wrap_sel_r;
			OFS_FILT: begin
				v[BIT_EMPH]  = emph_r;
				v[BIT_SDSEL] = sdsel_r;
			end
			OFS_PIN: begin
				v[BIT_GPIO2_DRIVE_ENABLE]   = gpio2_drive_enable_r;
				v[BIT_MUTE_LINE_ENABLE] = mute_line_enable_r;
				v[BIT_GPIO0_DRIVE_ENABLE]   = gpio0_drive_enable_r;
			end
			default: v = '0;
		endcase
		return v;
	endfunction

	// Reset release through two flip-flops
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	// Two-stage synchronisers for the lock indicator and the audio pins
	always_ff @(posedge sys_clk_i or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			in_meta_r <= '0;
			in_sync_r <= '0;
		end else begin
			in_meta_r <= {pll_raw_lock_i, pre_sdata_i, post_sdata_i};
			in_sync_r <= in_meta_r;
		end
	end

	assign lock_s = in_sync_r[2];
	assign pre_s  = in_sync_r[1];
	assign post_s = in_sync_r[0];

	// Access qualification; a load cycle only moves the pointer and page
	assign access  = (ctl_wr_i || ctl_rd_i) && !ctl_load_i;
	assign in_bank = (ctl_book_i == BOOK_ZERO) && (page_r == PAGE_ZERO);
	assign wr_hit  = ctl_wr_i && !ctl_load_i && in_bank;
	assign rd_hit  = ctl_rd_i && !ctl_load_i && in_bank;

	// Next values of pointer, control bits, status and read data
	always_comb begin
		ptr_nxt        = ptr_r;
		page_nxt       = page_r;
		left_mute_nxt  = left_mute_r;
		right_mute_nxt = right_mute_r;
		pll_en_nxt     = pll_en_r;
		wrap_sel_nxt   = wrap_sel_r;
		emph_nxt       = emph_r;
		sdsel_nxt      = sdsel_r;
		gpio2_drive_enable_nxt       = gpio2_drive_enable_r;
		mute_line_enable_nxt     = mute_line_enable_r;
		gpio0_drive_enable_nxt       = gpio0_drive_enable_r;
		if (ctl_load_i) begin
			ptr_nxt  = ctl_addr_i;
			page_nxt = ctl_page_i;
		end else if (access) begin
			if (ptr_r != PAGE_END) begin
				ptr_nxt = ptr_r + 1'b1;
			end else if (wrap_sel_r || ctl_book_i == BOOK_ZERO) begin
				ptr_nxt = SAME_PAGE_START;
			end else begin
				ptr_nxt  = NEXT_PAGE_START;
				page_nxt = page_r + 1'b1;
			end
		end
		if (wr_hit) begin
			case (ptr_r)
				OFS_MUTE: begin
					left_mute_nxt  = ctl_wdata_i[BIT_LMUTE];
					right_mute_nxt = ctl_wdata_i[BIT_RMUTE];
				end
				OFS_PLL:  pll_en_nxt   = ctl_wdata_i[BIT_PLLEN];
				OFS_WRAP: wrap_sel_nxt = ctl_wdata_i[BIT_WRAP];
				OFS_FILT: begin
					emph_nxt  = ctl_wdata_i[BIT_EMPH];
					sdsel_nxt = ctl_wdata_i[BIT_SDSEL];
				end
				OFS_PIN: begin
					gpio2_drive_enable_nxt   = ctl_wdata_i[BIT_GPIO2_DRIVE_ENABLE];
					mute_line_enable_nxt = ctl_wdata_i[BIT_MUTE_LINE_ENABLE];
					gpio0_drive_enable_nxt   = ctl_wdata_i[BIT_GPIO0_DRIVE_ENABLE];
				end
				default: ;
			endcase
		end
		unlock_nxt  = !(pll_en_nxt && lock_s);
		clk_pin_nxt = !pll_en_nxt;
		serial_audio_output_nxt   = sdsel_r ? pre_s : post_s;
		rvalid_nxt  = ctl_rd_i && !ctl_load_i;
		rdata_nxt   = rd_hit ? reg_image(ptr_r) : '0;
	end

	// Register stage of the whole bank
	always_ff @(posedge sys_clk_i or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			ptr_r        <= SAME_PAGE_START;
			page_r       <= PAGE_ZERO;
			left_mute_r  <= RST_LMUTE;
			right_mute_r <= RST_RMUTE;
			pll_en_r     <= RST_PLLEN;
			wrap_sel_r   <= RST_WRAP;
			emph_r       <= RST_EMPH;
			sdsel_r      <= RST_SDSEL;
			gpio2_drive_enable_r       <= RST_GPIO2_DRIVE_ENABLE;
			mute_line_enable_r     <= RST_MUTE_LINE_ENABLE;
			gpio0_drive_enable_r       <= RST_GPIO0_DRIVE_ENABLE;
			unlock_r     <= 1'b1;
			clk_pin_r    <= 1'b0;
			serial_audio_output_r      <= 1'b0;
			rvalid_r     <= 1'b0;
			rdata_r      <= '0;
		end else begin
			ptr_r        <= ptr_nxt;
			page_r       <= page_nxt;
			left_mute_r  <= left_mute_nxt;
			right_mute_r <= right_mute_nxt;
			pll_en_r     <= pll_en_nxt;
			wrap_sel_r   <= wrap_sel_nxt;
			emph_r       <= emph_nxt;
			sdsel_r      <= sdsel_nxt;
			gpio2_drive_enable_r       <= gpio2_drive_enable_nxt;
			mute_line_enable_r     <= mute_line_enable_nxt;
			gpio0_drive_enable_r       <= gpio0_drive_enable_nxt;
			unlock_r     <= unlock_nxt;
			clk_pin_r    <= clk_pin_nxt;
			serial_audio_output_r      <= serial_audio_output_nxt;
			rvalid_r     <= rvalid_nxt;
			rdata_r      <= rdata_nxt;
		end
	end

	// One volume ramp per channel: index 0 left, 1 right
	ramp_if #(.GAIN_W(GAIN_W)) rif [2] ();

	assign rif[0].mute_req = left_mute_r;
	assign rif[1].mute_req = right_mute_r;

	for (genvar g = 0; g < 2; g++) begin : g_ramp
		volume_ramp #(
			.GAIN_W   (GAIN_W),
			.STEP_CYC (STEP_CYC)
		) u_ramp (
			.sys_clk_i (sys_clk_i),
			.rst_n_i   (rst_sync_r),
			.bus       (rif[g].ramp)
		);
	end

	// Outputs, each from a flip-flop
	assign ctl_rdata_o            = rdata_r;
	assign ctl_rvalid_o           = rvalid_r;
	assign ctl_ptr_o              = ptr_r;
	assign ctl_page_o             = page_r;
	assign pll_enable_o           = pll_en_r;
	assign mclk_from_pin_o        = clk_pin_r;
	assign pll_lock_flag_o        = unlock_r;
	assign left_gain_o            = rif[0].gain;
	assign right_gain_o           = rif[1].gain;
	assign left_muted_o           = rif[0].muted;
	assign right_muted_o          = rif[1].muted;
	assign emphasis_undo_enable_o = emph_r;
	assign serial_audio_output_o  = serial_audio_output_r;
	assign gpio2_drive_enable_o   = gpio2_drive_enable_r;
	assign gpio0_drive_enable_o   = gpio0_drive_enable_r;
	assign mute_line_enable_o     = mute_line_enable_r;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_sync_r);

	sequence s_end_of_page;
		access && !ctl_load_i && ptr_r == PAGE_END;
	endsequence

	a_left_mute_write: assert property (wr_hit && ptr_r == OFS_MUTE
		|=> left_mute_r == $past(ctl_wdata_i[BIT_LMUTE]))
		else $error("left mute request not stored");
	a_right_mute_write: assert property (wr_hit && ptr_r == OFS_MUTE
		|=> right_mute_r == $past(ctl_wdata_i[BIT_RMUTE]))
		else $error("right mute request not stored");
	a_lock_flag_locked: assert property (pll_en_r && lock_s && !wr_hit
		|=> !pll_lock_flag_o)
		else $error("lock flag not 0 while locked");
	a_lock_flag_disabled: assert property (!pll_en_r |-> pll_lock_flag_o)
		else $error("lock flag shows locked with PLL disabled");
	a_pll_clock_source: assert property (wr_hit && ptr_r == OFS_PLL
		|=> pll_enable_o == $past(ctl_wdata_i[BIT_PLLEN]) && mclk_from_pin_o != pll_enable_o)
		else $error("PLL enable or clock source wrong after write");
	a_wrap_next_page: assert property (s_end_of_page and (!wrap_sel_r
		&& ctl_book_i != BOOK_ZERO) |=> ptr_r == NEXT_PAGE_START && page_r == $past(page_r) + 1'b1)
		else $error("no advance to next page");
	a_wrap_same_page: assert property (s_end_of_page and wrap_sel_r
		|=> ptr_r == SAME_PAGE_START && $stable(page_r))
		else $error("no wrap within the page");
	a_emphasis_enable: assert property (wr_hit && ptr_r == OFS_FILT
		|=> emphasis_undo_enable_o == $past(ctl_wdata_i[BIT_EMPH]))
		else $error("de-emphasis enable not applied");
	a_serial_audio_output_source: assert property (sdsel_r |=> serial_audio_output_o == $past(pre_s))
		else $error("serial output not from pre-processing stream");
	a_gpio_direction: assert property (wr_hit && ptr_r == OFS_PIN
		|=> gpio2_drive_enable_o == $past(ctl_wdata_i[BIT_GPIO2_DRIVE_ENABLE])
		&& gpio0_drive_enable_o == $past(ctl_wdata_i[BIT_GPIO0_DRIVE_ENABLE]))
		else $error("pin direction not applied");
	a_mute_line_enable: assert property (wr_hit && ptr_r == OFS_PIN
		|=> mute_line_enable_o == $past(ctl_wdata_i[BIT_MUTE_LINE_ENABLE]))
		else $error("mute line enable not applied");
	a_reserved_zero: assert property (rd_hit && ptr_r == OFS_MUTE
		|=> ctl_rvalid_o && ctl_rdata_o[7:5] == 3'h0 && ctl_rdata_o[3:1] == 3'h0)
		else $error("reserved bits read nonzero");

endmodule // audio_dac_control_regs

// [tb/ctl_host.sv]
// Host side of the control port: issues pointer loads, byte writes and byte reads.
// Assumes the bank's strobe protocol; every strobe lasts exactly one clock cycle.
`timescale 1ns/1ps
module ctl_host (
	input  wire logic                               sys_clk_i,
	input  wire logic [audio_ctl_pkg::DATA_W-1:0]   ctl_rdata_i,
	input  wire logic                               ctl_rvalid_i,
	output logic                                    ctl_load_o,
	output logic      [audio_ctl_pkg::ADDR_W-1:0]   ctl_addr_o,
	output logic      [audio_ctl_pkg::PAGE_W-1:0]   ctl_page_o,
	output logic      [audio_ctl_pkg::BOOK_W-1:0]   ctl_book_o,
	output logic                                    ctl_wr_o,
	output logic      [audio_ctl_pkg::DATA_W-1:0]   ctl_wdata_o,
	output logic                                    ctl_rd_o
);
	import audio_ctl_pkg::*;

	// Idle levels at time zero
	initial begin
		ctl_load_o  = 1'b0;
		ctl_addr_o  = 7'h00;
		ctl_page_o  = 8'h00;
		ctl_book_o  = 8'h00;
		ctl_wr_o    = 1'b0;
		ctl_wdata_o = 8'h00;
		ctl_rd_o    = 1'b0;
	end

	// Select the book held by the front end
	task automatic set_book(input logic [BOOK_W-1:0] b);
		@(posedge sys_clk_i);
		ctl_book_o <= b;
	endtask

	// Load pointer and page in one strobe cycle
	task automatic load(input logic [ADDR_W-1:0] a, input logic [PAGE_W-1:0] pg);
		@(posedge sys_clk_i);
		ctl_load_o <= 1'b1;
		ctl_addr_o <= a;
		ctl_page_o <= pg;
		@(posedge sys_clk_i);
		ctl_load_o <= 1'b0;
		ctl_addr_o <= ~a;
	endtask

	// One byte write; data line shows garbage once released
	task automatic wr(input logic [DATA_W-1:0] d);
		@(posedge sys_clk_i);
		ctl_wr_o    <= 1'b1;
		ctl_wdata_o <= d;
		@(posedge sys_clk_i);
		ctl_wr_o    <= 1'b0;
		ctl_wdata_o <= ~d;
	endtask

	// One byte read; answer is taken in the cycle after the strobe
	task automatic rd(output logic [DATA_W-1:0] d, output logic v);
		@(posedge sys_clk_i);
		ctl_rd_o <= 1'b1;
		@(posedge sys_clk_i);
		ctl_rd_o <= 1'b0;
		#1;
		d = ctl_rdata_i;
		v = ctl_rvalid_i;
	endtask
endmodule // ctl_host

// [tb/audio_dac_control_regs_test.sv]
// Self-checking bench for the audio control register bank.
// Assumes ctl_host as the control port master and a shortened ramp step.
`timescale 1ns/1ps
module audio_dac_control_regs_test;
	import audio_ctl_pkg::*;

	logic                sys_clk_i;
	logic                rst_n_i;
	logic                pll_raw_lock_i;
	logic                pre_sdata_i;
	logic                post_sdata_i;
	logic                ctl_load_i;
	logic                ctl_wr_i;
	logic                ctl_rd_i;
	logic                ctl_rvalid_o;
	logic [ADDR_W-1:0]   ctl_addr_i;
	logic [ADDR_W-1:0]   ctl_ptr_o;
	logic [PAGE_W-1:0]   ctl_page_i;
	logic [PAGE_W-1:0]   ctl_page_o;
	logic [BOOK_W-1:0]   ctl_book_i;
	logic [DATA_W-1:0]   ctl_wdata_i;
	logic [DATA_W-1:0]   ctl_rdata_o;
	logic [7:0]          left_gain_o;
	logic [7:0]          right_gain_o;
	logic                pll_enable_o, mclk_from_pin_o, pll_lock_flag_o;
	logic                left_muted_o, right_muted_o, emphasis_undo_enable_o;
	logic                serial_audio_output_o, gpio2_drive_enable_o;
	logic                gpio0_drive_enable_o, mute_line_enable_o;
	int                  mismatches = 0;
	int                  checked    = 0;

	audio_dac_control_regs #(.GAIN_W(8), .STEP_CYC(2)) uut (.*);

	ctl_host h (.sys_clk_i(sys_clk_i), .ctl_rdata_i(ctl_rdata_o), .ctl_rvalid_i(ctl_rvalid_o),
		.ctl_load_o(ctl_load_i), .ctl_addr_o(ctl_addr_i), .ctl_page_o(ctl_page_i),
		.ctl_book_o(ctl_book_i), .ctl_wr_o(ctl_wr_i), .ctl_wdata_o(ctl_wdata_i),
		.ctl_rd_o(ctl_rd_i));

	// 125 MHz core clock
	initial begin
		sys_clk_i = 1'b0;
		forever #4 sys_clk_i = ~sys_clk_i;
	end

	// Verdict and end of run
	task automatic end_sim();
		$display("checked=%0d mismatches=%0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Compare one byte-wide result
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Register write and checked register read in book 0 page 0
	task automatic wreg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		h.load(a, 8'h00);
		h.wr(d);
	endtask

	task automatic rchk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic       v;
		h.load(a, 8'h00);
		h.rd(d, v);
		chk({7'h00, v}, 8'h01);
		chk(d, exp);
	endtask

	// Values after reset
	task automatic t_reset();
		rchk(OFS_MUTE, 8'h00);
		rchk(OFS_PLL,  8'h11);
		rchk(OFS_WRAP, 8'h00);
		rchk(OFS_FILT, 8'h01);
		rchk(OFS_PIN,  8'h00);
		chk({7'h00, serial_audio_output_o}, 8'h01);
	endtask

	// Lock flag follows the loop only while the PLL is enabled
	task automatic t_pll();
		@(posedge sys_clk_i) pll_raw_lock_i <= 1'b1;
		repeat (5) @(posedge sys_clk_i);
		rchk(OFS_PLL, 8'h01);
		chk({7'h00, pll_lock_flag_o}, 8'h00);
		wreg(OFS_PLL, 8'hEE);
		rchk(OFS_PLL, 8'h10);
		chk({6'h00, mclk_from_pin_o, pll_enable_o}, 8'h02);
		wreg(OFS_PLL, 8'h01);
		rchk(OFS_PLL, 8'h01);
		chk({6'h00, mclk_from_pin_o, pll_enable_o}, 8'h01);
		@(posedge sys_clk_i) pll_raw_lock_i <= 1'b0;
		repeat (5) @(posedge sys_clk_i);
		rchk(OFS_PLL, 8'h11);
	endtask

	// Soft mute ramps down and back up on each channel
	task automatic t_mute();
		wreg(OFS_MUTE, 8'hFE);
		rchk(OFS_MUTE, 8'h10);
		repeat (6) @(posedge sys_clk_i);
		chk({7'h00, left_gain_o == 8'h00 || left_gain_o == 8'hFF}, 8'h00);
		for (int n = 0; n < 2000 && left_muted_o !== 1'b1; n++) @(posedge sys_clk_i);
		chk({6'h00, left_muted_o, right_muted_o}, 8'h02);
		chk(left_gain_o, 8'h00);
		chk(right_gain_o, 8'hFF);
		wreg(OFS_MUTE, 8'h01);
		for (int n = 0; n < 2000 && right_muted_o !== 1'b1; n++) @(posedge sys_clk_i);
		chk({7'h00, right_muted_o}, 8'h01);
		chk(right_gain_o, 8'h00);
		chk(left_gain_o, 8'hFF);
		wreg(OFS_MUTE, 8'h00);
		for (int n = 0; n < 2000 && right_gain_o !== 8'hFF; n++) @(posedge sys_clk_i);
		chk({right_gain_o[7:1], right_muted_o}, 8'hFE);
	endtask

	// Filter, output select and pin bits, reserved bits masked
	task automatic t_fields();
		wreg(OFS_FILT, 8'hFF);
		rchk(OFS_FILT, 8'h11);
		chk({7'h00, emphasis_undo_enable_o}, 8'h01);
		wreg(OFS_FILT, 8'hEE);
		rchk(OFS_FILT, 8'h00);
		repeat (5) @(posedge sys_clk_i);
		chk({7'h00, serial_audio_output_o}, 8'h00);
		@(posedge sys_clk_i) post_sdata_i <= 1'b1;
		repeat (5) @(posedge sys_clk_i);
		chk({7'h00, serial_audio_output_o}, 8'h01);
		wreg(OFS_PIN, 8'hFF);
		rchk(OFS_PIN, 8'h38);
		chk({5'h00, gpio2_drive_enable_o, mute_line_enable_o, gpio0_drive_enable_o}, 8'h07);
		wreg(OFS_PIN, 8'h10);
		@(negedge sys_clk_i);
		chk({5'h00, gpio2_drive_enable_o, mute_line_enable_o, gpio0_drive_enable_o}, 8'h02);
		rchk(7'h05, 8'h00);
	endtask

	// Serial output follows the selected stream, three cycles behind the pins
	task automatic t_stream(input logic sel, input logic [7:0] pat);
		wreg(OFS_FILT, {7'h00, sel});
		for (int i = 0; i < 8; i++) begin
			@(posedge sys_clk_i);
			pre_sdata_i  <= pat[i];
			post_sdata_i <= ~pat[i];
			repeat (4) @(posedge sys_clk_i);
			chk({7'h00, serial_audio_output_o}, {7'h00, sel ? pat[i] : ~pat[i]});
		end
	endtask

	// Auto-increment across a page end
	task automatic t_wrap();
		logic [7:0] d;
		logic       v;
		wreg(OFS_WRAP, 8'hFF);
		rchk(OFS_WRAP, 8'h08);
		h.set_book(8'h01);
		h.load(PAGE_END, 8'h02);
		h.rd(d, v);
		chk(d, 8'h00);
		chk({1'b0, ctl_ptr_o}, 8'h00);
		chk(ctl_page_o, 8'h02);
		h.load(OFS_MUTE, 8'h00);
		h.wr(8'h10);
		h.set_book(8'h00);
		rchk(OFS_MUTE, 8'h00);
		wreg(OFS_WRAP, 8'h00);
		h.set_book(8'h01);
		h.load(PAGE_END, 8'h02);
		h.rd(d, v);
		chk({1'b0, ctl_ptr_o}, 8'h08);
		chk(ctl_page_o, 8'h03);
		h.set_book(8'h00);
	endtask

	// Watchdog for a hung run
	initial begin
		repeat (30000) @(posedge sys_clk_i);
		mismatches++;
		end_sim();
	end

	// Main sequence
	initial begin
		rst_n_i        = 1'b0;
		pll_raw_lock_i = 1'b0;
		pre_sdata_i    = 1'b1;
		post_sdata_i   = 1'b0;
		repeat (8) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge sys_clk_i);
		t_reset();
		t_pll();
		t_mute();
		t_fields();
		t_stream(1'b1, 8'hA5);
		t_stream(1'b0, 8'h3C);
		t_wrap();
		end_sim();
	end
endmodule // audio_dac_control_regs_test
